/* File: core/sfwg_guard.sv */
// Write guard of a serial NOR flash: command checks, protection, busy timing.
//
// Overview of operation
// [RL1] Page program busy about 2 ms, below 3 ms.
// [RL2] Every erase busy about 8 ms, below 20 ms.
// [RL3] Host waits 150 us after power before commands.
// [RL4] Status reads zero from the start.
// [RL5] Control returns to standby at power-up.
// [RL6] Data-changing commands must end on byte boundary.
// [RL7] Changes need the write latch flag set.
// [RL8] Low protect pin freezes protect and lock bits.
// [RL9] Deep sleep ignores all but the wake command.
// [RL10] 2M coarse: 00 none, 11 whole array.
// [RL11] 2M coarse: quarter or half, top or bottom.
// [RL12] 2M fine: 4K to 32K or all.
// [RL13] 1M coarse: half or whole array.
// [RL14] 1M fine: 4K to 32K or all.
// [RL15] Writes touching protected range are ignored.
// [RL16] Latch set command sets flag, clear clears.
// [RL17] Commands during a busy period are ignored.
// [RL18] Busy shown while running; flag cleared at end.
// [RL19] Host polls busy before next change.
`timescale 1ns/1ps
`default_nettype none
`include "sfwg_map.svh"

module sfwg_guard import sfwg_pkg::*; #(
  parameter bit          DENSITY_2M = 1'h1,
  parameter int unsigned PROG_CYC   = `SFWG_PROG_CYC,
  parameter int unsigned ERASE_CYC  = `SFWG_ERASE_CYC,
  parameter int unsigned REGWR_CYC  = `SFWG_REGWR_CYC,
  parameter int unsigned PWR_CYC    = `SFWG_PWR_CYC
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        nrst,
  // Serial command port pins, asynchronous to clk.
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        sdi,
  input  wire logic        protect_pin_n,
  // State seen by the rest of the device.
  output logic [7:0]       status,
  output logic             busy,
  output logic             ready,
  output logic             deep_sleep,
  output logic             cmd_done,
  output logic             cmd_drop
);
  localparam int TW = 23;

  initial begin
    if (PROG_CYC < 1 || ERASE_CYC < 1 || REGWR_CYC < 1 || PWR_CYC < 1 ||
        PROG_CYC >= (1 << TW) || ERASE_CYC >= (1 << TW) ||
        REGWR_CYC >= (1 << TW) || PWR_CYC >= (1 << TW))
      $error("sfwg_guard: cycle count out of range");
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [3:0]  s1_r, s2_r;
  logic        sclk_d_r, sel_d_r;
  logic        sclk_rise, sel_rise, sel_act, wp_low;

  // Bits are {protect, data, select, clock}; idle level is deselected.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_r     <= 4'hA;
      s2_r     <= 4'hA;
      sclk_d_r <= 1'h0;
      sel_d_r  <= 1'h1;
    end else begin
      s1_r     <= {protect_pin_n, sdi, sel_n, sclk};
      s2_r     <= s1_r;
      sclk_d_r <= s2_r[0];
      sel_d_r  <= s2_r[1];
    end
  end
  assign sclk_rise = s2_r[0] & ~sclk_d_r;
  assign sel_rise  = s2_r[1] & ~sel_d_r;
  assign sel_act   = ~s2_r[1];
  assign wp_low    = ~s2_r[3];

  // ------------------------------------------------------------
  // Frame capture
  // ------------------------------------------------------------
  logic [11:0] cnt_r;
  logic [31:0] sh_r;
  logic [7:0]  op_r, dat_r;
  logic [23:0] addr_r;

  // Bits are taken on rising serial clock; count saturates on long programs.
  always_ff @(posedge clk) begin
    if (!nrst || !sel_act) begin
      cnt_r <= 12'h000;
    end else if (sclk_rise && cnt_r != 12'hFFF) begin
      cnt_r <= cnt_r + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sh_r   <= 32'h0000_0000;
      op_r   <= 8'h00;
      dat_r  <= 8'h00;
      addr_r <= 24'h00_0000;
    end else if (sclk_rise && sel_act) begin
      sh_r <= {sh_r[30:0], s2_r[2]};
      if (cnt_r == 12'h007) op_r   <= {sh_r[6:0], s2_r[2]};
      if (cnt_r == 12'h00F) dat_r  <= {sh_r[6:0], s2_r[2]};
      if (cnt_r == 12'h01F) addr_r <= {sh_r[22:0], s2_r[2]};
    end
  end

  // ------------------------------------------------------------
  // Decode and checks at the end of a frame
  // ------------------------------------------------------------
  logic        is_set, is_clr, is_reg, is_prog, is_erase, is_chip;
  logic        is_sleep, is_wake, changes, len_ok, hit, eval, allowed;
  logic [17:0] top, a, span, tlo, thi, plo, phi;
  logic        pnone;
  logic [4:0]  bp_r;
  logic        lock_r, wel_r, dpd_r, ready_r;
  sfwg_state_t state_r;

  sfwg_prot_range #(.DENSITY_2M(DENSITY_2M)) u_range (
    .bp   (bp_r),
    .none (pnone),
    .lo   (plo),
    .hi   (phi)
  );

  always_comb begin
    top      = DENSITY_2M ? `SFWG_TOP_2M : `SFWG_TOP_1M;
    is_set   = (op_r == `SFWG_OP_LATCH_SET);
    is_clr   = (op_r == `SFWG_OP_LATCH_CLR);
    is_reg   = (op_r == `SFWG_OP_REG_WRITE);
    is_prog  = (op_r == `SFWG_OP_PROGRAM);
    is_erase = (op_r == `SFWG_OP_PAGE_ERASE) || (op_r == `SFWG_OP_SECT_ERASE)
            || (op_r == `SFWG_OP_B32_ERASE) || (op_r == `SFWG_OP_B64_ERASE);
    is_chip  = (op_r == `SFWG_OP_CHIP_ERA_A) || (op_r == `SFWG_OP_CHIP_ERA_B);
    is_sleep = (op_r == `SFWG_OP_SLEEP);
    is_wake  = (op_r == `SFWG_OP_WAKE);
    changes  = is_reg | is_prog | is_erase | is_chip;
    // Exact length per command, a minimum length for program; always a whole number of bytes.
    len_ok = (cnt_r[2:0] == 3'h0) && (                           // RL6
             ((is_set | is_clr | is_chip | is_sleep | is_wake)
               && cnt_r == `SFWG_LEN_SHORT)
          || (is_reg && cnt_r == `SFWG_LEN_REG)
          || (is_erase && cnt_r == `SFWG_LEN_ADDR)
          || (is_prog && cnt_r >= `SFWG_LEN_PROG));
    // Target region of the operation, aligned to its own erase unit.
    a = addr_r[17:0] & top;
    unique case (op_r)
      `SFWG_OP_SECT_ERASE: span = `SFWG_SPAN_SECT;
      `SFWG_OP_B32_ERASE:  span = `SFWG_SPAN_B32;
      `SFWG_OP_B64_ERASE:  span = `SFWG_SPAN_B64;
      default:             span = `SFWG_SPAN_PAGE;
    endcase
    tlo = is_chip ? 18'h0_0000 : (a & ~span);
    thi = is_chip ? top : ((a & ~span) | span);
    hit = !pnone && !(thi < plo || tlo > phi);                   // RL15
    // Before the power-up wait ends nothing is taken.
    eval    = sel_rise && ready_r && cnt_r != 12'h000;           // RL3
    allowed = len_ok && state_r == ST_IDLE                       // RL17
           && (!dpd_r || is_wake)                                // RL9
           && (!changes || wel_r)                                // RL7
           && !((is_prog | is_erase | is_chip) && hit);          // RL15
  end

  // ------------------------------------------------------------
  // Power-up wait
  // ------------------------------------------------------------
  logic [TW-1:0] pwr_r;

  // Counting on clk alone keeps the wait honest whatever the host does.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwr_r   <= '0;
      ready_r <= 1'h0;
    end else if (!ready_r) begin
      pwr_r   <= pwr_r + 23'h00_0001;
      ready_r <= (pwr_r == TW'(PWR_CYC - 1));
    end
  end

  // ------------------------------------------------------------
  // Operation timer and protection state
  // ------------------------------------------------------------
  logic [TW-1:0] tmr_r;
  sfwg_kind_t    kind_r;
  logic          start, done;

  assign start = eval && allowed && changes;
  assign done  = state_r == ST_BUSY && tmr_r == '0;

  // Standby after reset; typical times are used, well inside the limits.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;                                        // RL5
      tmr_r   <= '0;
      kind_r  <= OPK_NONE;
    end else begin
      unique case (state_r)
        ST_IDLE: if (start) begin
          state_r <= ST_BUSY;
          if (is_prog) begin
            tmr_r  <= TW'(PROG_CYC - 1);                         // RL1
            kind_r <= OPK_PROG;
          end else if (is_reg) begin
            tmr_r  <= TW'(REGWR_CYC - 1);
            kind_r <= OPK_REG;
          end else begin
            tmr_r  <= TW'(ERASE_CYC - 1);                        // RL2
            kind_r <= OPK_ERASE;
          end
        end
        ST_BUSY: if (done) begin
          state_r <= ST_IDLE;                                    // RL18
        end else begin
          tmr_r <= tmr_r - 23'h00_0001;
        end
      endcase
    end
  end

  // Write latch: set and clear commands, dropped when a period ends.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wel_r <= 1'h0;                                             // RL4
    end else if (done) begin
      wel_r <= 1'h0;                                             // RL18
    end else if (eval && allowed && is_set) begin
      wel_r <= 1'h1;                                             // RL16
    end else if (eval && allowed && is_clr) begin
      wel_r <= 1'h0;                                             // RL16
    end
  end

  // Protect and lock bits; a low protect pin keeps them as they are.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bp_r   <= 5'h00;                                           // RL4
      lock_r <= 1'h0;
    end else if (start && is_reg && !wp_low) begin               // RL8
      bp_r   <= dat_r[6:2];
      lock_r <= dat_r[7];
    end
  end

  // Deep sleep and the one-cycle command outcome pulses.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dpd_r    <= 1'h0;
      cmd_done <= 1'h0;
      cmd_drop <= 1'h0;
    end else begin
      if (eval && allowed && is_sleep) dpd_r <= 1'h1;
      if (eval && allowed && is_wake)  dpd_r <= 1'h0;           // RL9
      cmd_done <= eval && allowed;
      cmd_drop <= eval && !allowed;
    end
  end

  assign status     = {lock_r, bp_r, wel_r, state_r == ST_BUSY};
  assign busy       = (state_r == ST_BUSY);                      // RL18
  assign ready      = ready_r;
  assign deep_sleep = dpd_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [TW-1:0] blen_r;
  always_ff @(posedge clk) begin
    if (!nrst) blen_r <= '0;
    else       blen_r <= busy ? blen_r + 23'h00_0001 : '0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_reg_write_held;
    start && is_reg && wp_low;
  endsequence

  a_prog_time: assert property ($fell(busy) && kind_r == OPK_PROG |-> // RL1
    blen_r == TW'(PROG_CYC)) else $error("program period wrong");
  a_erase_time: assert property ($fell(busy) && kind_r == OPK_ERASE |-> // RL2
    blen_r == TW'(ERASE_CYC)) else $error("erase period wrong");
  a_reset_status: assert property ($rose(nrst) |-> status == 8'h00) // RL4
    else $error("status not zero after reset");
  a_reset_idle: assert property ($rose(nrst) |-> !busy && !dpd_r) // RL5
    else $error("not standby after reset");
  a_len_drop: assert property (eval && !len_ok && !busy |=> // RL6
    !busy && !cmd_done) else $error("bad length accepted");
  a_latch_need: assert property (eval && changes && !wel_r && !busy |=> // RL7
    !busy) else $error("change without latch");
  a_wp_freeze: assert property (s_reg_write_held |=> // RL8
    $stable(bp_r) && $stable(lock_r) && busy) else $error("protect bits moved");
  a_sleep_ignore: assert property (eval && dpd_r && !is_wake |=> // RL9
    dpd_r && !busy && cmd_drop) else $error("command taken in sleep");
  a_prot_hit: assert property (eval && hit && changes && !is_reg && !busy // RL15
    |=> !busy) else $error("protected target started");
  a_latch_set: assert property (eval && allowed && is_set |=> wel_r) // RL16
    else $error("latch not set");
  a_busy_ignore: assert property (busy && eval |=> // RL17
    $stable(status[7:2]) && cmd_drop) else $error("command taken while busy");
  a_done_clear: assert property ($fell(busy) |-> !wel_r) // RL18
    else $error("latch kept after period");
  a_range_all: assert property (DENSITY_2M && bp_r == 5'h03 |-> // RL10
    !pnone && plo == 18'h0_0000 && phi == 18'h3_FFFF) else $error("all wrong");
  a_range_half: assert property (DENSITY_2M && bp_r == 5'h0A |-> // RL11
    plo == 18'h0_0000 && phi == 18'h1_FFFF) else $error("half wrong");
  a_range_fine: assert property (DENSITY_2M && bp_r == 5'h11 |-> // RL12
    plo == 18'h3_F000 && phi == 18'h3_FFFF) else $error("4K wrong");
  a_range_1m: assert property (!DENSITY_2M && bp_r == 5'h01 |-> // RL13
    plo == 18'h1_0000 && phi == 18'h1_FFFF) else $error("1M half wrong");
  a_range_1mf: assert property (!DENSITY_2M && bp_r == 5'h1C |-> // RL14
    plo == 18'h0_0000 && phi == 18'h0_7FFF) else $error("1M 32K wrong");
endmodule // sfwg_guard
`default_nettype wire

/* File: core/sfwg_map.svh */
// Constants of the serial flash write guard: opcodes, status reset value, times.
`ifndef SFWG_MAP_SVH
`define SFWG_MAP_SVH

// ------------------------------------------------------------
// Clock and operation times
// ------------------------------------------------------------
`define SFWG_CLK_NS        4
`define SFWG_PROG_TYP_MS   2
`define SFWG_ERASE_TYP_MS  8
`define SFWG_REGWR_TYP_MS  8
`define SFWG_PWR_WAIT_US   150
`define SFWG_PROG_CYC  (`SFWG_PROG_TYP_MS * 1000000 / `SFWG_CLK_NS)
`define SFWG_ERASE_CYC (`SFWG_ERASE_TYP_MS * 1000000 / `SFWG_CLK_NS)
`define SFWG_REGWR_CYC (`SFWG_REGWR_TYP_MS * 1000000 / `SFWG_CLK_NS)
`define SFWG_PWR_CYC   ((`SFWG_PWR_WAIT_US * 1000 + `SFWG_CLK_NS - 1) / `SFWG_CLK_NS)

// ------------------------------------------------------------
// Command opcodes
// ------------------------------------------------------------
`define SFWG_OP_LATCH_SET   8'h06
`define SFWG_OP_LATCH_CLR   8'h04
`define SFWG_OP_REG_WRITE   8'h01
`define SFWG_OP_PROGRAM     8'h02
`define SFWG_OP_PAGE_ERASE  8'h81
`define SFWG_OP_SECT_ERASE  8'h20
`define SFWG_OP_B32_ERASE   8'h52
`define SFWG_OP_B64_ERASE   8'hD8
`define SFWG_OP_CHIP_ERA_A  8'h60
`define SFWG_OP_CHIP_ERA_B  8'hC7
`define SFWG_OP_SLEEP       8'hB9
`define SFWG_OP_WAKE        8'hAB

// ------------------------------------------------------------
// Status reset value, lengths in bits, array tops, spans
// ------------------------------------------------------------
`define SFWG_ST_RESET     8'h00
`define SFWG_LEN_SHORT    12'h008
`define SFWG_LEN_REG      12'h010
`define SFWG_LEN_ADDR     12'h020
`define SFWG_LEN_PROG     12'h028
`define SFWG_TOP_2M       18'h3_FFFF
`define SFWG_TOP_1M       18'h1_FFFF
`define SFWG_SPAN_PAGE    18'h0_00FF
`define SFWG_SPAN_SECT    18'h0_0FFF
`define SFWG_SPAN_B32     18'h0_7FFF
`define SFWG_SPAN_B64     18'h0_FFFF

`endif

/* File: core/sfwg_pkg.sv */
// Types shared by the serial flash write guard.
package sfwg_pkg;
  typedef enum logic [1:0] {OPK_NONE, OPK_PROG, OPK_ERASE, OPK_REG} sfwg_kind_t;
  typedef enum logic {ST_IDLE, ST_BUSY} sfwg_state_t;
endpackage

/* File: core/sfwg_prot_range.sv */
// Decoder from the block-protect bits to a protected address range.
`timescale 1ns/1ps
`default_nettype none
`include "sfwg_map.svh"

module sfwg_prot_range import sfwg_pkg::*; #(
  parameter bit DENSITY_2M = 1'h1
) (
  // Block-protect bits: granularity, bottom select, size 2..0.
  input  wire logic [4:0]  bp,
  // Resulting range, inclusive.
  output logic             none,
  output logic [17:0]      lo,
  output logic [17:0]      hi
);
  logic [17:0] top;
  logic [18:0] size;

  // Size first, then placement; the whole array is top placement of full size.
  always_comb begin
    top  = DENSITY_2M ? `SFWG_TOP_2M : `SFWG_TOP_1M;
    size = 19'h0_0000;
    if (!bp[4]) begin
      if (DENSITY_2M) begin
        case (bp[1:0])                                 // RL10 RL11
          2'h0:    size = 19'h0_0000;
          2'h1:    size = 19'h1_0000;
          2'h2:    size = 19'h2_0000;
          default: size = {1'h0, top} + 19'h0_0001;
        endcase
      end else if (bp[1]) begin
        size = {1'h0, top} + 19'h0_0001;               // RL13
      end else if (bp[0]) begin
        size = 19'h1_0000;                             // RL13
      end
    end else begin
      case (bp[2:0])                                   // RL12 RL14
        3'h0:    size = 19'h0_0000;
        3'h1:    size = 19'h0_1000;
        3'h2:    size = 19'h0_2000;
        3'h3:    size = 19'h0_4000;
        3'h7:    size = {1'h0, top} + 19'h0_0001;
        default: size = 19'h0_8000;
      endcase
    end
    none = (size == 19'h0_0000);
    // Bottom placement starts at zero, top placement ends at the array top.
    if (bp[3]) begin                                   // RL11 RL14
      lo = 18'h0_0000;
      hi = 18'(size - 19'h0_0001);
    end else begin
      lo = 18'(({1'h0, top} + 19'h0_0001) - size);
      hi = top;
    end
  end
endmodule // sfwg_prot_range
`default_nettype wire

/* File: bench/sfwg_host.sv */
// Host controller model that drives frames onto the serial command port.
`timescale 1ns/1ps
`default_nettype none

module sfwg_host (
  // Clock of the device side and its power-up indication.
  input  wire logic clk,
  input  wire logic ready,
  // Serial command port pins.
  output logic      sclk,
  output logic      sel_n,
  output logic      sdi
);
  // ----------------------------------------------------------
  // Idle pins
  // ----------------------------------------------------------
  // The serial clock stands still low between frames.
  initial begin
    sclk  = 1'b0;
    sel_n = 1'b1;
    sdi   = 1'b0;
  end

  // ----------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------
  // Pins move on falling clk edges, so the device never sees a change
  // at its own sampling edge; the link clock runs about 124 ns a bit.
  task automatic send(input logic [47:0] bits, input int n);
    int i;
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 1000) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    sel_n = 1'b0;
    for (i = 0; i < n; i++) begin
      sdi = bits[47-i];
      repeat (15) @(negedge clk);
      sclk = 1'b1;
      repeat (16) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (8) @(negedge clk);
    sel_n = 1'b1;
    sdi   = ~sdi; // Released line shows no stale value.
  endtask
endmodule // sfwg_host

`default_nettype wire

/* File: bench/serial_flash_write_guard_bench.sv */
// Self-checking bench of the serial flash write guard.
`timescale 1ns/1ps
`default_nettype none
`include "sfwg_map.svh"

module serial_flash_write_guard_bench import sfwg_pkg::*; ;
  // ----------------------------------------------------------
  // Signals and short counts
  // ----------------------------------------------------------
  // The register write period is long so a frame fits inside it.
  localparam int P_PROG  = 20;
  localparam int P_ERASE = 40;
  localparam int P_REG   = 600;
  localparam int P_PWR   = 10;
  logic       clk    = 1'b0;
  logic       nrst   = 1'b0;
  logic       prot_n = 1'b1;
  wire        sclk;
  wire        sel_n;
  wire        sdi;
  logic [7:0] status;
  logic       busy, ready, deep_sleep, cmd_done, cmd_drop;
  int         fails = 0;
  int         comparisons = 0;
  int         got, bcnt, i, k, n, span;
  logic [7:0] op, d;
  logic [4:0] bp;
  logic [17:0] a;

  // Design and host model.
  sfwg_guard #(.DENSITY_2M(1'b1), .PROG_CYC(P_PROG), .ERASE_CYC(P_ERASE),
    .REGWR_CYC(P_REG), .PWR_CYC(P_PWR)) u_sfwg_guard (.clk(clk),
    .nrst(nrst), .sclk(sclk), .sel_n(sel_n), .sdi(sdi),
    .protect_pin_n(prot_n), .status(status), .busy(busy), .ready(ready),
    .deep_sleep(deep_sleep), .cmd_done(cmd_done), .cmd_drop(cmd_drop));
  sfwg_host u_host (.clk(clk), .ready(ready), .sclk(sclk), .sel_n(sel_n),
    .sdi(sdi));

  // 250 MHz clock.
  initial begin
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------
  // Verdict and the end of the run.
  task automatic close_out;
    $display("counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Value of a design output against its expectation.
  task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Answer code or cycle count against its expectation.
  task automatic chk_n(input int g, input int e);
    comparisons++;
    if (g != e) begin
      fails++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Sends a frame; got is 1 for accepted, 2 for refused, 0 for silence.
  // The full 12-cycle wait also keeps the gap between frames.
  task automatic cmd(input logic [47:0] b, input int nb);
    int j;
    u_host.send(b, nb);
    got  = 0;
    bcnt = 0;
    for (j = 0; j < 12; j++) begin
      @(negedge clk);
      if (cmd_done === 1'b1) got = 1;
      if (cmd_drop === 1'b1) got = 2;
      if (busy === 1'b1) bcnt++;
    end
  endtask

  // Waits for the busy period to end, counting its cycles.
  task automatic idle;
    int j;
    for (j = 0; j < 2000 && busy === 1'b1; j++) begin
      @(negedge clk);
      if (busy === 1'b1) bcnt++;
    end
    if (j == 2000) begin
      fails++;
      close_out();
    end
  endtask

  // Latch set ahead of every change.
  task automatic latch;
    cmd({`SFWG_OP_LATCH_SET, 40'h00_0000_0000}, 8);
  endtask

  // Whether a target range meets the protected range of the 2M table.
  function automatic bit hit(logic [4:0] p, logic [17:0] lo_t,
                             logic [17:0] hi_t);
    int sz;
    int lo;
    int hi;
    if (!p[4]) begin
      case (p[1:0])
        2'h0:    sz = 0;
        2'h1:    sz = 32'h0001_0000;
        2'h2:    sz = 32'h0002_0000;
        default: sz = 32'h0004_0000;
      endcase
    end else begin
      case (p[2:0])
        3'h0:    sz = 0;
        3'h1:    sz = 32'h0000_1000;
        3'h2:    sz = 32'h0000_2000;
        3'h3:    sz = 32'h0000_4000;
        3'h7:    sz = 32'h0004_0000;
        default: sz = 32'h0000_8000;
      endcase
    end
    if (sz == 0) return 1'b0;
    lo = p[3] ? 0 : 32'h0004_0000 - sz;
    hi = p[3] ? sz - 1 : 32'h0003_FFFF;
    if (sz == 32'h0004_0000) lo = 0;
    if (sz == 32'h0004_0000) hi = 32'h0003_FFFF;
    return !(int'(hi_t) < lo || int'(lo_t) > hi);
  endfunction

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    void'($urandom(32'h922e_d29c));
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    chk_v(status, `SFWG_ST_RESET);
    chk_v(busy, 8'h00);
    chk_v(ready, 8'h00);
    repeat (P_PWR + 3) @(negedge clk);
    chk_v(ready, 8'h01);
    $display("test reset done");
    cmd({`SFWG_OP_LATCH_SET, 40'h00_0000_0000}, 8);
    chk_n(got, 1);
    chk_v(status[1], 8'h01);
    cmd({`SFWG_OP_LATCH_CLR, 40'h00_0000_0000}, 8);
    chk_v(status[1], 8'h00);
    cmd({`SFWG_OP_SECT_ERASE, 40'h00_0000_0000}, 32);
    chk_n(got, 2);
    latch();
    cmd({`SFWG_OP_SECT_ERASE, 40'h00_0000_0000}, 31);
    chk_n(got, 2);
    cmd({`SFWG_OP_SECT_ERASE, 40'h00_0000_0000}, 33);
    chk_n(got, 2);
    $display("test latch and length done");
    d = $urandom;
    latch();
    cmd({`SFWG_OP_REG_WRITE, d, 32'h0000_0000}, 16);
    chk_n(got, 1);
    chk_v(status[7:2], d[7:2]);
    chk_v(status[0], 8'h01);
    cmd({`SFWG_OP_LATCH_SET, 40'h00_0000_0000}, 8);
    chk_n(got, 2);
    idle();
    chk_v(status[1], 8'h00);
    prot_n = 1'b0;
    latch();
    cmd({`SFWG_OP_REG_WRITE, ~d, 32'h0000_0000}, 16);
    idle();
    chk_v(status[7:2], d[7:2]);
    prot_n = 1'b1;
    $display("test register write done");
    cmd({`SFWG_OP_SLEEP, 40'h00_0000_0000}, 8);
    chk_v(deep_sleep, 8'h01);
    cmd({`SFWG_OP_LATCH_SET, 40'h00_0000_0000}, 8);
    chk_n(got, 2);
    cmd({`SFWG_OP_WAKE, 40'h00_0000_0000}, 8);
    chk_n(got, 1);
    chk_v(deep_sleep, 8'h00);
    $display("test deep sleep done");
    for (i = 0; i < 14; i++) begin
      bp = $urandom;
      latch();
      cmd({`SFWG_OP_REG_WRITE, 1'b0, bp, 2'h0, 32'h0000_0000}, 16);
      idle();
      chk_v(status[6:2], bp);
      k = $urandom_range(0, 5);
      a = (i == 0) ? 18'h0_0000 : (i == 1) ? `SFWG_TOP_2M : 18'($urandom);
      n = 32;
      case (k)
        0: {op, span} = {`SFWG_OP_PAGE_ERASE, 32'(`SFWG_SPAN_PAGE)};
        1: {op, span} = {`SFWG_OP_SECT_ERASE, 32'(`SFWG_SPAN_SECT)};
        2: {op, span} = {`SFWG_OP_B32_ERASE, 32'(`SFWG_SPAN_B32)};
        3: {op, span} = {`SFWG_OP_B64_ERASE, 32'(`SFWG_SPAN_B64)};
        4: {op, span} = {i[0] ? `SFWG_OP_CHIP_ERA_A : `SFWG_OP_CHIP_ERA_B,
                         32'(`SFWG_TOP_2M)};
        default: {op, span} = {`SFWG_OP_PROGRAM, 32'(`SFWG_SPAN_PAGE)};
      endcase
      if (k == 4) n = 8;
      if (k == 5) n = 40;
      latch();
      cmd({op, 6'h00, a, 16'($urandom)}, n);
      chk_n(got, hit(bp, a & ~span[17:0], a | span[17:0]) ? 2 : 1);
      if (got == 1) begin
        idle();
        chk_n(bcnt, (k == 5) ? P_PROG : P_ERASE);
        chk_v(status[1:0], 8'h00);
      end
    end
    $display("test protection done");
    close_out();
  end
endmodule // serial_flash_write_guard_bench

`default_nettype wire
